// >>> lcdsp_pkg.sv
/*
  Shared constants and types of the type B serial command port.
  Assumes a 32 x 4 display RAM and a host that opens every frame with a mode ID.
*/
package lcdsp_pkg;

  localparam int RAM_AW    = 5;
  localparam int RAM_DW    = 4;
  localparam int ADDR_BITS = 6;

  // Mode IDs.
  localparam logic [2:0] ID_READ  = 3'h6;
  localparam logic [2:0] ID_WRITE = 3'h5;
  localparam logic [2:0] ID_CMD   = 3'h4;

  // Index of the last bit of each field, counted from zero.
  localparam logic [3:0] ID_LAST   = 4'h2;
  localparam logic [3:0] ADDR_LAST = 4'h5;
  localparam logic [3:0] DATA_LAST = 4'h3;
  localparam logic [3:0] CMD_LAST  = 4'h8;

  // Command codes, eight bits, the ninth bit is ignored.
  localparam logic [7:0] CMD_SYSTEM_DISABLE   = 8'h00;
  localparam logic [7:0] CMD_SYSTEM_ENABLE    = 8'h01;
  localparam logic [7:0] CMD_BIAS_OFF  = 8'h02;
  localparam logic [7:0] CMD_BIAS_ON   = 8'h03;
  localparam logic [7:0] CMD_EFT       = 8'hE3;
  localparam logic [7:0] CMD_ANALOG    = 8'hF4;
  localparam logic [7:0] CMD_DISPLAY   = 8'hF5;
  localparam logic [7:0] CMD_SW_RESET  = 8'hF0;
  localparam logic [6:0] CMD_MODE_SEL  = 7'h7E;
  localparam logic [6:0] CMD_STATIC    = 7'h79;
  localparam logic [3:0] CMD_SRC_GRP   = 4'h1;
  localparam logic [3:0] CMD_BIAS_GRP  = 4'h2;
  localparam logic [3:0] ANALOG2_LOW   = 4'hB;
  localparam logic [1:0] SRC_NONE      = 2'h0;
  localparam logic [1:0] SRC_EXT       = 2'h3;
  localparam logic [1:0] COMMONS_2     = 2'h0;
  localparam logic [1:0] COMMONS_4     = 2'h2;
  localparam logic [1:0] COMMONS_BAD   = 2'h3;

  // Field positions inside command words.
  localparam int POS_SRC_LO   = 2;
  localparam int POS_COM_LO   = 2;
  localparam int POS_BIAS     = 0;
  localparam int POS_REG_DIS  = 5;
  localparam int POS_FOL_DIS  = 4;
  localparam int POS_COM_REV  = 3;
  localparam int POS_SEG_REV  = 2;
  localparam int POS_INVERT   = 1;
  localparam int POS_ALL_ON   = 0;

  typedef enum logic [2:0] {
    LK_ID   = 3'h0,
    LK_ADDR = 3'h1,
    LK_DATA = 3'h2,
    LK_CMD  = 3'h3,
    LK_READ = 3'h4,
    LK_HOLD = 3'h5
  } lcdsp_link_t;

  typedef enum logic [1:0] {
    DC_NONE    = 2'h0,
    DC_ANALOG  = 2'h1,
    DC_DISPLAY = 2'h2
  } lcdsp_dbl_t;

  typedef struct packed {
    logic       system_enable;
    logic       bias_on;
    logic       external_clock_source;
    logic       bias_third;
    logic [1:0] commons;
    logic       extended_set_flag;
    logic       regulator_disable;
    logic       follower_disable;
    logic       common_scan_reverse;
    logic       segment_reverse;
    logic       display_invert;
    logic       all_pixels_on;
    logic       static_drive;
  } lcdsp_cfg_t;

  localparam lcdsp_cfg_t CFG_RESET = '{1'b0, 1'b0, 1'b0, 1'b0, COMMONS_4, 1'b0,
                                        1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};

  typedef struct packed {
    logic [ADDR_BITS-1:0] addr;
    logic [RAM_DW-1:0]    data;
  } lcdsp_wreq_t;

  // Levels and toggles that cross into the system clock.
  typedef struct packed {
    logic cs_n;
    logic sel_hi;
    logic sel_lo;
    logic rtog;
    logic ctog;
    logic wtog;
    logic atog;
  } lcdsp_xing_t;

endpackage

// >>> lcdsp_sync.sv
/*
  Two flip-flop synchroniser for a vector of independent levels.
  Assumes each bit changes slowly compared with the clock.
*/
module lcdsp_sync #(
  parameter int W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_nrst,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      meta_reg <= '0;
      o_q      <= '0;
    end
    else
    begin
      meta_reg <= i_d;
      o_q      <= meta_reg;
    end
  end
endmodule // lcdsp_sync

// >>> lcdsp_ram.sv
/*
  Display RAM with one write port and two registered read ports.
  Assumes all ports run on the same clock.
*/
module lcdsp_ram #(
  parameter int AW = 5,
  parameter int DW = 4
) (
  input  wire logic          i_clk,
  input  wire logic          i_nrst,
  input  wire logic          i_we,
  input  wire logic [AW-1:0] i_waddr,
  input  wire logic [DW-1:0] i_wdata,
  input  wire logic [AW-1:0] i_raddr_a,
  output logic      [DW-1:0] o_q_a,
  input  wire logic [AW-1:0] i_raddr_b,
  output logic      [DW-1:0] o_q_b
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge i_clk)
  begin
    if (i_we)
    begin
      mem[i_waddr] <= i_wdata;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_q_a <= '0;
      o_q_b <= '0;
    end
    else
    begin
      o_q_a <= mem[i_raddr_a];
      o_q_b <= mem[i_raddr_b];
    end
  end
endmodule // lcdsp_ram

// >>> lcdsp_port.sv
/*
  Type B four-line serial command and data port with display RAM and settings.
  Assumes the host drives chip select, write strobe and read strobe, shares one
  data line, and leaves enough time between strobes for the crossings.
*/
module lcdsp_port
  import lcdsp_pkg::*;
(
  input  wire logic              i_clk,
  input  wire logic              i_nrst,
  input  wire logic              i_link_wr_clk,
  input  wire logic              i_link_rd_clk,
  input  wire logic              i_chip_select_n,
  input  wire logic              i_data_in,
  output logic                   o_data_out,
  output logic                   o_data_oe,
  input  wire logic              i_interface_select_low_bit,
  input  wire logic              i_interface_select_high_bit,
  input  wire logic [RAM_AW-1:0] i_disp_addr,
  output logic      [RAM_DW-1:0] o_disp_data,
  output lcdsp_cfg_t             o_cfg,
  output logic                   o_type_b_active,
  output logic                   o_reserved_seen
);

  // System reset, released through two flip-flops.
  logic rst_meta_reg;
  logic rst_n;

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      rst_meta_reg <= 1'b0;
      rst_n        <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_n        <= rst_meta_reg;
    end
  end

  // ---------------- Write strobe domain ----------------
  lcdsp_link_t          st_reg,   st_next;
  logic [3:0]           cnt_reg,  cnt_next;
  logic [8:0]           sh_reg,   sh_next;
  logic                 wmode_reg, wmode_next;
  logic [ADDR_BITS-1:0] addr_reg, addr_next;
  lcdsp_wreq_t          wreq_reg, wreq_next;
  logic [7:0]           cmd_reg,  cmd_next;
  logic                 atog_reg, atog_next;
  logic                 wtog_reg, wtog_next;
  logic                 ctog_reg, ctog_next;
  wire  [2:0]           id_word  = {sh_reg[1:0], i_data_in};
  wire  [RAM_DW-1:0]    nib_word = {i_data_in, sh_reg[0], sh_reg[1], sh_reg[2]};

  always_comb
  begin
    st_next    = st_reg;
    cnt_next   = cnt_reg + 4'h1;
    sh_next    = {sh_reg[7:0], i_data_in};
    wmode_next = wmode_reg;
    addr_next  = addr_reg;
    wreq_next  = wreq_reg;
    cmd_next   = cmd_reg;
    atog_next  = atog_reg;
    wtog_next  = wtog_reg;
    ctog_next  = ctog_reg;
    case (st_reg)
      LK_ID:
      begin
        if (cnt_reg == ID_LAST)
        begin
          cnt_next = 4'h0;
          if (id_word == ID_READ)
          begin
            st_next    = LK_ADDR;
            wmode_next = 1'b0;
          end
          else if (id_word == ID_WRITE)
          begin
            st_next    = LK_ADDR;
            wmode_next = 1'b1;
          end
          else if (id_word == ID_CMD)
          begin
            st_next = LK_CMD;
          end
          else
          begin
            st_next = LK_HOLD;
          end
        end
      end
      LK_ADDR:
      begin
        if (cnt_reg == ADDR_LAST)
        begin
          cnt_next  = 4'h0;
          addr_next = {sh_reg[4:0], i_data_in};
          atog_next = ~atog_reg;
          st_next   = wmode_reg ? LK_DATA : LK_READ;
        end
      end
      LK_DATA:
      begin
        if (cnt_reg == DATA_LAST)
        begin
          cnt_next       = 4'h0;
          wreq_next.addr = addr_reg;
          wreq_next.data = nib_word;
          wtog_next      = ~wtog_reg;
          addr_next      = addr_reg + 6'h01;
        end
      end
      LK_CMD:
      begin
        if (cnt_reg == CMD_LAST)
        begin
          cnt_next  = 4'h0;
          cmd_next  = sh_reg[7:0];
          ctog_next = ~ctog_reg;
        end
      end
      default:
      begin
        cnt_next = cnt_reg;
      end
    endcase
  end

  // Chip select high clears the framing state.
  always_ff @(posedge i_link_wr_clk or posedge i_chip_select_n)
  begin
    if (i_chip_select_n)
    begin
      st_reg    <= LK_ID;
      cnt_reg   <= 4'h0;
      sh_reg    <= 9'h000;
      wmode_reg <= 1'b0;
    end
    else
    begin
      st_reg    <= st_next;
      cnt_reg   <= cnt_next;
      sh_reg    <= sh_next;
      wmode_reg <= wmode_next;
    end
  end

  // Payload and toggles survive chip select so no crossing event is lost.
  always_ff @(posedge i_link_wr_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      addr_reg <= '0;
      wreq_reg <= '0;
      cmd_reg  <= 8'h00;
      atog_reg <= 1'b0;
      wtog_reg <= 1'b0;
      ctog_reg <= 1'b0;
    end
    else
    begin
      addr_reg <= (st_reg == LK_ID) ? addr_reg : addr_next;
      wreq_reg <= wreq_next;
      cmd_reg  <= cmd_next;
      atog_reg <= atog_next;
      wtog_reg <= wtog_next;
      ctog_reg <= ctog_next;
    end
  end

  // ---------------- Read strobe domain ----------------
  logic [1:0]        rbit_reg;
  logic              dout_reg;
  logic              oe_reg;
  logic              rtog_reg;
  logic [RAM_DW-1:0] rd_nib;

  always_ff @(negedge i_link_rd_clk or posedge i_chip_select_n)
  begin
    if (i_chip_select_n)
    begin
      rbit_reg <= 2'h0;
      dout_reg <= 1'b0;
      oe_reg   <= 1'b0;
    end
    else
    begin
      dout_reg <= rd_nib[rbit_reg];
      rbit_reg <= rbit_reg + 2'h1;
      oe_reg   <= 1'b1;
    end
  end

  // Each completed nibble tells the system side to step to the next address.
  always_ff @(negedge i_link_rd_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      rtog_reg <= 1'b0;
    end
    else if (!i_chip_select_n && rbit_reg == 2'h3)
    begin
      rtog_reg <= ~rtog_reg;
    end
  end

  // The device releases the line from the first falling write strobe of the data field.
  // Waiting for the first captured bit would let the device drive that bit itself.
  logic host_own_reg;

  always_ff @(negedge i_link_wr_clk or posedge i_chip_select_n)
  begin
    if (i_chip_select_n)
    begin
      host_own_reg <= 1'b0;
    end
    else if (st_reg == LK_DATA)
    begin
      host_own_reg <= 1'b1;
    end
  end

  wire host_writing = host_own_reg;
  assign o_data_out = dout_reg;
  assign o_data_oe  = oe_reg & ~host_writing & o_type_b_active;

  // ---------------- System clock domain ----------------
  lcdsp_xing_t     xing_in;
  lcdsp_xing_t     xing_q;
  lcdsp_xing_t     prev_reg;
  lcdsp_cfg_t      cfg_reg,  cfg_next;
  lcdsp_dbl_t      dbl_reg,  dbl_next;
  logic [RAM_AW-1:0] ptr_reg, ptr_next;
  logic            test_next;
  logic            typeb_reg;

  assign xing_in = '{i_chip_select_n, i_interface_select_high_bit, i_interface_select_low_bit,
                     rtog_reg, ctog_reg, wtog_reg, atog_reg};

  lcdsp_sync #(
    .W ($bits(lcdsp_xing_t))
  ) u_sync (
    .i_clk  (i_clk),
    .i_nrst (rst_n),
    .i_d    (xing_in),
    .o_q    (xing_q)
  );

  wire ev_a    = xing_q.atog ^ prev_reg.atog;
  wire ev_w    = xing_q.wtog ^ prev_reg.wtog;
  wire ev_c    = xing_q.ctog ^ prev_reg.ctog;
  wire ev_r    = xing_q.rtog ^ prev_reg.rtog;
  wire typeb_d = xing_q.sel_hi & xing_q.sel_lo;
  wire ram_we  = ev_w & typeb_reg;

  lcdsp_ram #(
    .AW (RAM_AW),
    .DW (RAM_DW)
  ) u_ram (
    .i_clk     (i_clk),
    .i_nrst    (rst_n),
    .i_we      (ram_we),
    .i_waddr   (wreq_reg.addr[RAM_AW-1:0]),
    .i_wdata   (wreq_reg.data),
    .i_raddr_a (ptr_reg),
    .o_q_a     (rd_nib),
    .i_raddr_b (i_disp_addr),
    .o_q_b     (o_disp_data)
  );

  always_comb
  begin
    cfg_next  = cfg_reg;
    dbl_next  = dbl_reg;
    ptr_next  = ptr_reg;
    test_next = 1'b0;
    if (ev_a)
    begin
      ptr_next = addr_reg[RAM_AW-1:0];
    end
    else if (ev_r)
    begin
      ptr_next = ptr_reg + 5'h01;
    end
    if (xing_q.cs_n)
    begin
      dbl_next = DC_NONE;
    end
    else if (ev_c && typeb_reg)
    begin
      if (dbl_reg == DC_ANALOG)
      begin
        dbl_next = DC_NONE;
        if (cmd_reg[3:0] == ANALOG2_LOW)
        begin
          cfg_next.regulator_disable = cmd_reg[POS_REG_DIS];
          cfg_next.follower_disable  = cmd_reg[POS_FOL_DIS];
        end
      end
      else if (dbl_reg == DC_DISPLAY)
      begin
        dbl_next                     = DC_NONE;
        cfg_next.common_scan_reverse = cmd_reg[POS_COM_REV];
        cfg_next.segment_reverse     = cmd_reg[POS_SEG_REV];
        cfg_next.display_invert      = cmd_reg[POS_INVERT];
        cfg_next.all_pixels_on       = cmd_reg[POS_ALL_ON];
      end
      else if (cmd_reg[7:1] == CMD_MODE_SEL)
      begin
        cfg_next.extended_set_flag = cmd_reg[0];
      end
      else if (!cfg_reg.extended_set_flag)
      begin
        if (cmd_reg == CMD_SYSTEM_DISABLE)
        begin
          cfg_next.system_enable = 1'b0;
          cfg_next.bias_on       = 1'b0;
        end
        else if (cmd_reg == CMD_SYSTEM_ENABLE)
        begin
          cfg_next.system_enable = 1'b1;
        end
        else if (cmd_reg == CMD_BIAS_OFF)
        begin
          cfg_next.bias_on = 1'b0;
        end
        else if (cmd_reg == CMD_BIAS_ON)
        begin
          cfg_next.bias_on = 1'b1;
        end
        else if (cmd_reg[7:4] == CMD_SRC_GRP && cmd_reg[3:2] != SRC_NONE)
        begin
          cfg_next.external_clock_source = (cmd_reg[POS_SRC_LO +: 2] == SRC_EXT);
        end
        else if (cmd_reg[7:4] == CMD_BIAS_GRP)
        begin
          cfg_next.bias_third = cmd_reg[POS_BIAS];
          if (cmd_reg[POS_COM_LO +: 2] != COMMONS_BAD)
          begin
            cfg_next.commons = cmd_reg[POS_COM_LO +: 2];
          end
        end
        else if (cmd_reg == CMD_EFT)
        begin
          test_next = 1'b1;
        end
      end
      else
      begin
        if (cmd_reg == CMD_ANALOG)
        begin
          dbl_next = DC_ANALOG;
        end
        else if (cmd_reg == CMD_DISPLAY)
        begin
          dbl_next = DC_DISPLAY;
        end
        else if (cmd_reg[7:1] == CMD_STATIC)
        begin
          cfg_next.static_drive = cmd_reg[0];
        end
        else if (cmd_reg == CMD_SW_RESET)
        begin
          cfg_next = CFG_RESET;
          ptr_next = '0;
        end
      end
    end
  end

  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prev_reg        <= '0;
      cfg_reg         <= CFG_RESET;
      dbl_reg         <= DC_NONE;
      ptr_reg         <= '0;
      typeb_reg       <= 1'b0;
      o_reserved_seen <= 1'b0;
    end
    else
    begin
      prev_reg        <= xing_q;
      cfg_reg         <= cfg_next;
      dbl_reg         <= dbl_next;
      ptr_reg         <= ptr_next;
      typeb_reg       <= typeb_d;
      o_reserved_seen <= test_next;
    end
  end

  assign o_cfg           = cfg_reg;
  assign o_type_b_active = typeb_reg;

endmodule // lcdsp_port

// >>> lcdsp_port_sva.sv
/*
  Checker on the pins and settings of the type B serial port.
  Assumes it is bound onto lcdsp_port and runs on its system clock and reset.
*/
module lcdsp_port_sva
  import lcdsp_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_nrst,
  input  wire logic       i_chip_select_n,
  input  wire logic       i_interface_select_low_bit,
  input  wire logic       i_interface_select_high_bit,
  input  wire logic       o_data_oe,
  input  wire lcdsp_cfg_t o_cfg,
  input  wire logic       o_type_b_active,
  input  wire logic       o_reserved_seen
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  a_reserved_pulse: assert property (o_reserved_seen |=> !o_reserved_seen)
    else $error("reserved flag held");
  a_reserved_table: assert property (o_reserved_seen |-> !o_cfg.extended_set_flag)
    else $error("reserved flag in extended set");
  a_oe_needs_cs: assert property (o_data_oe |-> !i_chip_select_n)
    else $error("data driven while deselected");
  a_oe_needs_typeb: assert property (o_data_oe |-> o_type_b_active)
    else $error("data driven outside type B");
  a_typeb_off: assert property (!i_interface_select_low_bit [*4] |=> !o_type_b_active)
    else $error("type B active with select low");
  a_typeb_on: assert property ((i_interface_select_low_bit && i_interface_select_high_bit) [*8]
    |=> o_type_b_active)
    else $error("type B not active");
  a_cfg_quiet: assert property (i_chip_select_n [*8] |-> $stable(o_cfg))
    else $error("settings moved without strobes");
  a_display_ext: assert property ($changed(o_cfg[4:1]) |-> $past(o_cfg.extended_set_flag))
    else $error("display bits moved in base set");
  a_analog_ext: assert property ($changed(o_cfg[6:5]) |-> $past(o_cfg.extended_set_flag))
    else $error("analog bits moved in base set");
  a_static_ext: assert property ($changed(o_cfg.static_drive) |-> $past(o_cfg.extended_set_flag))
    else $error("static drive moved in base set");

  cover property (o_reserved_seen);
  cover property ($rose(o_data_oe));
  cover property ($rose(o_cfg.extended_set_flag));
endmodule // lcdsp_port_sva

bind lcdsp_port lcdsp_port_sva u_sva (
  .i_clk                       (i_clk),
  .i_nrst                      (i_nrst),
  .i_chip_select_n             (i_chip_select_n),
  .i_interface_select_low_bit  (i_interface_select_low_bit),
  .i_interface_select_high_bit (i_interface_select_high_bit),
  .o_data_oe                   (o_data_oe),
  .o_cfg                       (o_cfg),
  .o_type_b_active             (o_type_b_active),
  .o_reserved_seen             (o_reserved_seen)
);

// >>> lcdsp_host.sv
/*
  Host model: chip select, write and read strobes and the shared data line.
  Assumes the bench resolves the line from the device enable and o_dat.
*/
module lcdsp_host (
  output logic      o_cs_n,
  output logic      o_wr,
  output logic      o_rd,
  output logic      o_dat,
  input  wire logic i_line
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    o_cs_n = 1'b1;
    o_wr   = 1'b1;
    o_rd   = 1'b1;
    o_dat  = 1'b0;
  end

  // A high pulse on select clears the device framing before each mode ID.
  task automatic open_frame();
    o_cs_n <= 1'b1;
    #107;
    o_cs_n <= 1'b0;
    #50;
  endtask

  task automatic close_frame();
    #50;
    o_cs_n <= 1'b1;
    #100;
  endtask

  // Sends n bits, highest first; the strobe stands still outside this task.
  task automatic send(input logic [8:0] v, input int n);
    for (int i = n - 1; i >= 0; i--)
    begin
      o_dat <= v[i];
      o_wr  <= 1'b0;
      #24;
      o_wr  <= 1'b1;
      #24;
    end
  endtask

  // Reads one nibble, lowest bit first; the released line gets a toggling fill.
  task automatic get4(output logic [3:0] d);
    #250;
    for (int i = 0; i < 4; i++)
    begin
      o_rd  <= 1'b0;
      o_dat <= ~o_dat;
      #24;
      o_rd  <= 1'b1;
      #12;
      d[i] = i_line;
      #12;
    end
  endtask
endmodule // lcdsp_host

// >>> tb_lcd_serial_cmd_port_type_b.sv
/*
  Self-checking bench of the type B serial port, driven through the host model.
  Assumes a 40 MHz system clock and a 48 ns strobe period inside frames.
*/
module tb_lcd_serial_cmd_port_type_b
  import lcdsp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic              i_clk = 1'b0;
  logic              i_nrst = 1'b0;
  logic              sel_lo = 1'b1;
  logic              sel_hi = 1'b1;
  logic [RAM_AW-1:0] disp_addr = '0;
  logic [RAM_DW-1:0] disp_data;
  logic              cs_n, wr, rd, hdat, line, dout, doe, typeb, res_seen;
  logic              res_flag = 1'b0;
  logic [3:0]        nib;
  lcdsp_cfg_t        cfg;
  int                bad_count = 0;
  int                tests_run = 0;
  // Rows: first code, second word, settings expected afterwards.
  logic [29:0]       rows [26] = '{
    {8'h01, 8'h00, 14'h2200}, {8'h03, 8'h00, 14'h3200}, {8'h02, 8'h00, 14'h2200},
    {8'h00, 8'h00, 14'h0200}, {8'h1C, 8'h00, 14'h0A00}, {8'h14, 8'h00, 14'h0200},
    {8'h1C, 8'h00, 14'h0A00}, {8'h18, 8'h00, 14'h0200}, {8'h25, 8'h00, 14'h0500},
    {8'h20, 8'h00, 14'h0000}, {8'h28, 8'h00, 14'h0200}, {8'h01, 8'h00, 14'h2200},
    {8'h03, 8'h00, 14'h3200}, {8'h1C, 8'h00, 14'h3A00}, {8'h25, 8'h00, 14'h3D00},
    {8'hE3, 8'h00, 14'h3D00}, {8'hFD, 8'h00, 14'h3D80}, {8'hF3, 8'h00, 14'h3D81},
    {8'hF4, 8'h3B, 14'h3DE1}, {8'hF5, 8'h0F, 14'h3DFF}, {8'hF5, 8'h05, 14'h3DEB},
    {8'hF4, 8'h1B, 14'h3DAB}, {8'hFC, 8'h00, 14'h3D2B}, {8'hF2, 8'h00, 14'h3D2B},
    {8'hFD, 8'h00, 14'h3DAB}, {8'hF0, 8'h00, 14'h0200}};

  assign line = doe ? dout : hdat;

  lcdsp_host host (.o_cs_n(cs_n), .o_wr(wr), .o_rd(rd), .o_dat(hdat), .i_line(line));

  lcdsp_port dut (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_link_wr_clk(wr), .i_link_rd_clk(rd),
    .i_chip_select_n(cs_n), .i_data_in(line), .o_data_out(dout), .o_data_oe(doe),
    .i_interface_select_low_bit(sel_lo), .i_interface_select_high_bit(sel_hi),
    .i_disp_addr(disp_addr), .o_disp_data(disp_data), .o_cfg(cfg),
    .o_type_b_active(typeb), .o_reserved_seen(res_seen));

  initial
  begin
    forever #12.5 i_clk = ~i_clk;
  end

  always @(posedge i_clk)
  begin
    if (res_seen === 1'b1) res_flag <= 1'b1;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic wait_typeb();
    int n;
    for (n = 0; n < 40 && typeb !== 1'b1; n++) @(posedge i_clk);
    if (n == 40)
    begin
      bad_count++;
      wrap_up();
    end
  endtask

  task automatic settle();
    repeat (12) @(posedge i_clk);
  endtask

  // Double commands take their second word in the same frame.
  task automatic cmd(input logic [7:0] c1, input logic [7:0] c2);
    host.open_frame();
    host.send({6'h00, ID_CMD}, 3);
    host.send({c1, 1'b1}, 9);
    if (c1 == CMD_ANALOG || c1 == CMD_DISPLAY) host.send({c2, 1'b1}, 9);
    host.close_frame();
    settle();
  endtask

  task automatic nib_out(input logic [3:0] d);
    host.send({5'h00, d[0], d[1], d[2], d[3]}, 4);
    #100;
  endtask

  task automatic disp(input logic [4:0] a, input logic [3:0] exp);
    @(posedge i_clk) disp_addr <= a;
    repeat (3) @(posedge i_clk);
    check(disp_data, exp);
  endtask

  task automatic data_frame(input logic [2:0] id, input logic [5:0] a);
    host.open_frame();
    host.send({6'h00, id}, 3);
    host.send({3'h0, a}, 6);
  endtask

  initial
  begin
    repeat (3) @(posedge i_clk);
    i_nrst <= 1'b1;
    check(cfg, 14'h0200);
    check(disp_data, 4'h0);
    wait_typeb();
    // The table sets every setting from power-on values before use.
    for (int r = 0; r < 26; r++)
    begin
      cmd(rows[r][29:22], rows[r][21:14]);
      check(cfg, rows[r][13:0]);
    end
    check(res_flag, 1'b1);
    $display("command table done");
    host.open_frame();
    host.send({6'h00, ID_CMD}, 3);
    host.send({CMD_SYSTEM_ENABLE, 1'b0}, 9);
    host.send({CMD_BIAS_ON, 1'b0}, 9);
    host.close_frame();
    settle();
    check(cfg, 14'h3200);
    host.open_frame();
    host.send({6'h00, ID_CMD}, 3);
    host.send(9'h000, 4);
    host.close_frame();
    host.open_frame();
    host.send({CMD_SYSTEM_DISABLE, 1'b0}, 9);
    host.close_frame();
    settle();
    check(cfg, 14'h3200);
    $display("framing done");
    @(posedge i_clk) sel_lo <= 1'b0;
    settle();
    check(typeb, 1'b0);
    cmd(CMD_SYSTEM_DISABLE, 8'h00);
    check(cfg, 14'h3200);
    @(posedge i_clk) sel_lo <= 1'b1;
    wait_typeb();
    $display("interface select done");
    data_frame(ID_WRITE, 6'h03);
    nib_out(4'hA);
    nib_out(4'h5);
    nib_out(4'hC);
    host.close_frame();
    disp(5'h03, 4'hA);
    disp(5'h04, 4'h5);
    disp(5'h05, 4'hC);
    data_frame(ID_WRITE, 6'h1F);
    nib_out(4'h6);
    host.close_frame();
    disp(5'h1F, 4'h6);
    data_frame(ID_READ, 6'h03);
    host.get4(nib);
    check(nib, 4'hA);
    host.get4(nib);
    check(nib, 4'h5);
    host.close_frame();
    data_frame(ID_WRITE, 6'h04);
    host.get4(nib);
    check(nib, 4'h5);
    nib_out(4'h9);
    host.close_frame();
    disp(5'h04, 4'h9);
    $display("ram access done");
    wrap_up();
  end
endmodule // tb_lcd_serial_cmd_port_type_b
